// *** i2c_host_command_interface.sv ***
`timescale 1ns/1ns
// Summary of operation
// - Works with bus bit rates up to 100 kbps and 400 kbps.
// - Transfers start from an idle bus or with a repeated START; master drives SCL and byte count.
// - Bytes move MSB first, each followed by one acknowledge slot.
// - Slave address low bit equals the sampled address select pin.
// - Direction bit 0 means write access, 1 means read access.
// - START is SDA falling while SCL stays high.
// - STOP is SDA rising while SCL stays high.
// - Repeated START behaves like START and opens a new address phase.
// - SDA changes only while SCL low; bits captured on SCL rising edge.
// - Read bits are driven after the previous SCL falling edge.
// - Acknowledging receiver holds SDA low over the ninth clock high phase.
// - When asleep, the address byte is not acknowledged; a busy line does not affect it.
// - Master leaves last read acknowledge high; device then releases SDA.
// - Write access carries a command code, optionally one parameter byte.
// - Surplus bytes and invalid parameters are never acknowledged.
// - Read bytes repeatedly return the register chosen by the read pointer.
// - Decoder knows device reset F0h, read pointer select E1h, config write D2h.
// - Decoder knows line reset B4h, single slot 87h, byte write A5h.
// - Decoder knows line byte read 96h and search triplet 78h.
// - Pointer code C3h selects config; invalid pointer codes are refused.
// - While the line is busy, line commands are refused and ignored.

module i2c_host_command_interface (
  // Clock and reset
  input wire logic mclk,
  input wire logic srst,
  input wire logic ce,
  // Bus pins
  input wire logic scl,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOeN,
  // Strap
  input wire logic addressSelectPin,
  // Core side
  input wire logic lineBusyFlag,
  input wire logic asleep,
  input wire i2c_host_pkg::regFileType regs,
  output i2c_host_pkg::cmdType cmd,
  output logic [7:0] readPointer
);

  i2c_host_pkg::stateType q;
  i2c_host_pkg::stateType d;
  logic sclNew;
  logic sdaNew;
  logic sclRise;
  logic sclFall;
  logic startDet;
  logic stopDet;
  logic addrMatch;
  logic codeKnown;
  logic codeNeedsParam;
  logic codeBusyRefused;
  logic paramOk;
  logic byteDone;
  logic [7:0] readByte;

  // ----------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------
  function automatic logic [7:0] nextPointer(input logic [7:0] code, input logic [7:0] param,
                                             input logic [7:0] current);
    logic [7:0] p;
    p = current;
    unique case (code)
      i2c_host_pkg::CMD_READ_POINTER_SELECT: p = param;
      i2c_host_pkg::CMD_CONFIG_WRITE: p = i2c_host_pkg::PTR_CONFIG;
      default: p = i2c_host_pkg::PTR_STATUS;
    endcase
    return p;
  endfunction : nextPointer

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    d = q;
    d.cmd.strobe = 1'b0;
    // Three stages; a change counts once stages two and three agree
    d.sclSync = {q.sclSync[1:0], scl};
    d.sdaSync = {q.sdaSync[1:0], sdaIn};
    d.adrSync = {q.adrSync[1:0], addressSelectPin};
    // Filter delay of a few cycles is far below a 400 kbps half period
    sclNew = (q.sclSync[1] == q.sclSync[2]) ? q.sclSync[2] : q.sclLvl;
    sdaNew = (q.sdaSync[1] == q.sdaSync[2]) ? q.sdaSync[2] : q.sdaLvl;
    d.sclLvl = sclNew;
    d.sdaLvl = sdaNew;
    d.adrLvl = (q.adrSync[1] == q.adrSync[2]) ? q.adrSync[2] : q.adrLvl;
    sclRise = !q.sclLvl && sclNew;
    sclFall = q.sclLvl && !sclNew;
    startDet = q.sclLvl && sclNew && q.sdaLvl && !sdaNew;
    stopDet = q.sclLvl && sclNew && !q.sdaLvl && sdaNew;
    byteDone = sclFall && (q.bitCnt == i2c_host_pkg::BITS_PER_BYTE);
    addrMatch = (q.shift[7:1] == {i2c_host_pkg::ADDR_UPPER_BITS, q.adrLvl});
    codeKnown = 1'b0;
    codeNeedsParam = 1'b0;
    codeBusyRefused = 1'b0;
    unique case (q.shift)
      i2c_host_pkg::CMD_DEVICE_RESET, i2c_host_pkg::CMD_LINE_RESET, i2c_host_pkg::CMD_LINE_BYTE_READ: begin
        codeKnown = 1'b1;
        codeBusyRefused = (q.shift != i2c_host_pkg::CMD_DEVICE_RESET);
      end
      i2c_host_pkg::CMD_READ_POINTER_SELECT: begin
        codeKnown = 1'b1;
        codeNeedsParam = 1'b1;
      end
      i2c_host_pkg::CMD_CONFIG_WRITE, i2c_host_pkg::CMD_LINE_SINGLE_SLOT, i2c_host_pkg::CMD_LINE_BYTE_WRITE,
      i2c_host_pkg::CMD_LINE_SEARCH_TRIPLET: begin
        codeKnown = 1'b1;
        codeNeedsParam = 1'b1;
        codeBusyRefused = 1'b1;
      end
      default: ;
    endcase
    // Only the pointer select parameter has a restricted set of values
    paramOk = (q.pendCode != i2c_host_pkg::CMD_READ_POINTER_SELECT) ||
              (q.shift == i2c_host_pkg::PTR_STATUS) || (q.shift == i2c_host_pkg::PTR_DATA) ||
              (q.shift == i2c_host_pkg::PTR_CONFIG);
    unique case (q.readPtr)
      i2c_host_pkg::PTR_DATA: readByte = regs.data;
      i2c_host_pkg::PTR_CONFIG: readByte = regs.cfg;
      default: readByte = regs.status;
    endcase
    if (startDet) begin
      // Repeated START needs no special path
      d.st = i2c_host_pkg::ST_ADDR;
      d.bitCnt = 4'h0;
      d.sdaOeN = 1'b1;
    end else if (stopDet) begin
      d.st = i2c_host_pkg::ST_IDLE;
      d.sdaOeN = 1'b1;
    end else begin
      unique case (q.st)
        i2c_host_pkg::ST_IDLE, i2c_host_pkg::ST_IGNORE: ;
        i2c_host_pkg::ST_ADDR: begin
          if (sclRise && q.bitCnt < i2c_host_pkg::BITS_PER_BYTE) begin
            d.shift = {q.shift[6:0], q.sdaLvl};
            d.bitCnt = 4'(q.bitCnt + 4'h1);
          end else if (byteDone) begin
            if (addrMatch && !asleep) begin
              d.sdaOeN = 1'b0;
              d.rw = q.shift[0];
              d.ph = i2c_host_pkg::PH_CMD;
              d.st = i2c_host_pkg::ST_ADDR_ACK;
            end else begin
              d.st = i2c_host_pkg::ST_IGNORE;
            end
          end
        end
        i2c_host_pkg::ST_WR_BYTE: begin
          if (sclRise && q.bitCnt < i2c_host_pkg::BITS_PER_BYTE) begin
            d.shift = {q.shift[6:0], q.sdaLvl};
            d.bitCnt = 4'(q.bitCnt + 4'h1);
          end else if (byteDone) begin
            d.st = i2c_host_pkg::ST_IGNORE;
            unique case (q.ph)
              i2c_host_pkg::PH_CMD: begin
                if (codeKnown && !(codeBusyRefused && lineBusyFlag)) begin
                  d.sdaOeN = 1'b0;
                  d.st = i2c_host_pkg::ST_WR_ACK;
                  d.pendCode = q.shift;
                  if (codeNeedsParam) begin
                    d.ph = i2c_host_pkg::PH_PARAM;
                  end else begin
                    d.ph = i2c_host_pkg::PH_DONE;
                    d.cmd = '{strobe: 1'b1, hasParam: 1'b0, code: q.shift, param: 8'h00};
                    d.readPtr = nextPointer(q.shift, 8'h00, q.readPtr);
                  end
                end
              end
              i2c_host_pkg::PH_PARAM: begin
                if (paramOk) begin
                  d.sdaOeN = 1'b0;
                  d.st = i2c_host_pkg::ST_WR_ACK;
                  d.ph = i2c_host_pkg::PH_DONE;
                  d.cmd = '{strobe: 1'b1, hasParam: 1'b1, code: q.pendCode, param: q.shift};
                  d.readPtr = nextPointer(q.pendCode, q.shift, q.readPtr);
                end
              end
              default: ;
            endcase
          end
        end
        i2c_host_pkg::ST_ADDR_ACK, i2c_host_pkg::ST_WR_ACK: begin
          if (sclFall) begin
            d.bitCnt = 4'h0;
            d.sdaOeN = 1'b1;
            d.st = i2c_host_pkg::ST_WR_BYTE;
            if (q.st == i2c_host_pkg::ST_ADDR_ACK && q.rw) begin
              d.shift = readByte;
              d.sdaOeN = readByte[7];
              d.bitCnt = 4'h1;
              d.st = i2c_host_pkg::ST_RD_BYTE;
            end
          end
        end
        i2c_host_pkg::ST_RD_BYTE: begin
          if (sclFall) begin
            if (q.bitCnt == i2c_host_pkg::BITS_PER_BYTE) begin
              d.sdaOeN = 1'b1;
              d.st = i2c_host_pkg::ST_RD_ACK;
            end else begin
              d.shift = {q.shift[6:0], 1'b0};
              d.sdaOeN = q.shift[6];
              d.bitCnt = 4'(q.bitCnt + 4'h1);
            end
          end
        end
        i2c_host_pkg::ST_RD_ACK: begin
          if (sclRise) begin
            d.masterAck = !q.sdaLvl;
          end else if (sclFall) begin
            if (q.masterAck) begin
              d.shift = readByte;
              d.sdaOeN = readByte[7];
              d.bitCnt = 4'h1;
              d.st = i2c_host_pkg::ST_RD_BYTE;
            end else begin
              d.sdaOeN = 1'b1;
              d.st = i2c_host_pkg::ST_IGNORE;
            end
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (srst) begin
      q <= i2c_host_pkg::STATE_RESET;
    end else if (ce) begin
      q <= d;
    end
  end

  assign sdaOut = q.sdaOut;
  assign sdaOeN = q.sdaOeN;
  assign cmd = q.cmd;
  assign readPointer = q.readPtr;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);

  sequence addrDecision;
    ce && q.st == i2c_host_pkg::ST_ADDR && byteDone && !startDet && !stopDet;
  endsequence

  sequence cmdDecision;
    ce && q.st == i2c_host_pkg::ST_WR_BYTE && q.ph == i2c_host_pkg::PH_CMD && byteDone && !startDet && !stopDet;
  endsequence

  startOpens_a: assert property (ce && startDet |=> q.st == i2c_host_pkg::ST_ADDR && q.bitCnt == 4'h0 && q.sdaOeN)
    else $error("START did not open an address phase");
  stopCloses_a: assert property (ce && stopDet |=> q.st == i2c_host_pkg::ST_IDLE && q.sdaOeN)
    else $error("STOP did not return to idle");
  addrMismatch_a: assert property (addrDecision and !addrMatch |=> q.sdaOeN && q.st == i2c_host_pkg::ST_IGNORE)
    else $error("Foreign address acknowledged");
  sleepNack_a: assert property (addrDecision and asleep |=> q.sdaOeN)
    else $error("Address acknowledged while asleep");
  addrAck_a: assert property (addrDecision and addrMatch && !asleep |=> !q.sdaOeN && q.rw == $past(q.shift[0]))
    else $error("Own address not acknowledged");
  busyRefuse_a: assert property (cmdDecision and lineBusyFlag && codeBusyRefused |=> q.sdaOeN && !q.cmd.strobe)
    else $error("Line command accepted while busy");
  ackHeld_a: assert property (ce && !q.sdaOeN && (q.st == i2c_host_pkg::ST_ADDR_ACK || q.st == i2c_host_pkg::ST_WR_ACK)
                              && sclRise |=> !q.sdaOeN)
    else $error("Acknowledge released during clock high");
  readChange_a: assert property ($changed(q.sdaOeN) && $past(q.st) == i2c_host_pkg::ST_RD_BYTE
                                 && q.st == i2c_host_pkg::ST_RD_BYTE |-> $past(sclFall))
    else $error("Read data changed away from a falling edge");
  masterNack_a: assert property (ce && q.st == i2c_host_pkg::ST_RD_ACK && !q.masterAck && sclFall && !startDet
                                 |=> q.sdaOeN && q.st == i2c_host_pkg::ST_IGNORE)
    else $error("SDA not released after master refusal");
  surplusNack_a: assert property (ce && q.st == i2c_host_pkg::ST_WR_BYTE && q.ph == i2c_host_pkg::PH_DONE && byteDone
                                  && !startDet && !stopDet |=> q.sdaOeN)
    else $error("Surplus byte acknowledged");
  pointerSel_a: assert property (ce && q.cmd.strobe && q.cmd.code == i2c_host_pkg::CMD_READ_POINTER_SELECT
                                 |-> q.readPtr == q.cmd.param ##1 !q.cmd.strobe)
    else $error("Read pointer not taken from parameter");

endmodule : i2c_host_command_interface

// *** i2c_host_pkg.sv ***
package i2c_host_pkg;

  // ----------------------------------------------------------------
  // Command codes
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_DEVICE_RESET = 8'hf0;
  localparam logic [7:0] CMD_READ_POINTER_SELECT = 8'he1;
  localparam logic [7:0] CMD_CONFIG_WRITE = 8'hd2;
  localparam logic [7:0] CMD_LINE_RESET = 8'hb4;
  localparam logic [7:0] CMD_LINE_SINGLE_SLOT = 8'h87;
  localparam logic [7:0] CMD_LINE_BYTE_WRITE = 8'ha5;
  localparam logic [7:0] CMD_LINE_BYTE_READ = 8'h96;
  localparam logic [7:0] CMD_LINE_SEARCH_TRIPLET = 8'h78;

  // ----------------------------------------------------------------
  // Read pointer codes
  // ----------------------------------------------------------------
  localparam logic [7:0] PTR_STATUS = 8'hf0;
  localparam logic [7:0] PTR_DATA = 8'he1;
  localparam logic [7:0] PTR_CONFIG = 8'hc3;

  // ----------------------------------------------------------------
  // Address and bus timing
  // ----------------------------------------------------------------
  // Upper six bits of the slave address, value is arbitrary
  localparam logic [5:0] ADDR_UPPER_BITS = 6'h0c;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam int CLK_PERIOD_NS = 8;
  localparam int STD_RATE_KBPS = 100;
  localparam int FAST_RATE_KBPS = 400;
  localparam int FAST_BIT_NS = 1000000 / FAST_RATE_KBPS;
  localparam int FAST_BIT_CYC = FAST_BIT_NS / CLK_PERIOD_NS;
  localparam int SYNC_STAGES = 3;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_WR_BYTE, ST_WR_ACK, ST_RD_BYTE, ST_RD_ACK, ST_IGNORE
  } busStateType;

  typedef enum logic [1:0] {PH_CMD, PH_PARAM, PH_DONE} wrPhaseType;

  typedef struct packed {
    logic [7:0] status;
    logic [7:0] data;
    logic [7:0] cfg;
  } regFileType;

  typedef struct packed {
    logic strobe;
    logic hasParam;
    logic [7:0] code;
    logic [7:0] param;
  } cmdType;

  typedef struct packed {
    logic [2:0] sclSync;
    logic [2:0] sdaSync;
    logic [2:0] adrSync;
    logic sclLvl;
    logic sdaLvl;
    logic adrLvl;
    busStateType st;
    wrPhaseType ph;
    logic [3:0] bitCnt;
    logic [7:0] shift;
    logic rw;
    logic masterAck;
    logic [7:0] pendCode;
    logic sdaOeN;
    logic sdaOut;
    cmdType cmd;
    logic [7:0] readPtr;
  } stateType;

  localparam stateType STATE_RESET = '{
    sclSync: 3'h7, sdaSync: 3'h7, adrSync: 3'h0, sclLvl: 1'b1, sdaLvl: 1'b1, adrLvl: 1'b0,
    st: ST_IDLE, ph: PH_CMD, bitCnt: 4'h0, shift: 8'h00, rw: 1'b0, masterAck: 1'b0,
    pendCode: 8'h00, sdaOeN: 1'b1, sdaOut: 1'b0, cmd: '0, readPtr: PTR_STATUS
  };

endpackage : i2c_host_pkg

// *** i2c_master_model.sv ***
`timescale 1ns/1ns
module i2c_master_model (
  // Clock
  input wire logic mclk,
  // Bus
  input wire logic sda,
  output logic scl,
  output logic drvLow
);

  // --------------------------------
  // Bus master
  // --------------------------------
  // Quarter bit time in mclk cycles, never below 4
  int tq = 12;

  initial begin
    scl = 1'b1;
    drvLow = 1'b0;
  end

  task automatic wt(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : wt

  // Data moves only while SCL is low
  task automatic bitx(input logic b, output logic s);
    drvLow = ~b;
    wt(tq);
    scl = 1'b1;
    wt(tq);
    s = sda;
    wt(tq);
    scl = 1'b0;
    wt(tq);
  endtask : bitx

  // Also serves as repeated start, as SCL is low on entry then
  task automatic start_cond;
    drvLow = 1'b0;
    wt(tq);
    scl = 1'b1;
    wt(tq);
    drvLow = 1'b1;
    wt(tq);
    scl = 1'b0;
    wt(tq);
  endtask : start_cond

  task automatic stop_cond;
    drvLow = 1'b1;
    wt(tq);
    scl = 1'b1;
    wt(tq);
    drvLow = 1'b0;
    wt(tq);
  endtask : stop_cond

  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bitx(d[i], s);
    end
    bitx(1'b1, s);
    ack = ~s;
  endtask : wbyte

  task automatic rbyte(input logic mack, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bitx(1'b1, d[i]);
    end
    bitx(~mack, s);
  endtask : rbyte

endmodule : i2c_master_model

// *** i2c_host_command_interface_tb_top.sv ***
`timescale 1ns/1ns
module i2c_host_command_interface_tb_top;

  // --------------------------------
  // Stimulus and wiring
  // --------------------------------
  logic mclk = 1'b0;
  logic srst = 1'b1;
  logic ce = 1'b1;
  logic addressSelectPin = 1'b0;
  logic lineBusyFlag = 1'b0;
  logic asleep = 1'b0;
  i2c_host_pkg::regFileType regs = '{status: 8'h5a, data: 8'ha6, cfg: 8'h3c};
  i2c_host_pkg::cmdType cmd;
  logic [7:0] readPointer;
  logic scl;
  logic drvLow;
  logic sdaOut;
  logic sdaOeN;
  // Pull-up and wired AND of both drivers
  wire sdaLine = ~drvLow & (sdaOeN | sdaOut);
  int err_total = 0;
  int n_checks = 0;
  int nStrobe = 0;

  always #4 mclk = ~mclk;

  always @(posedge mclk) if (cmd.strobe === 1'b1) nStrobe <= nStrobe + 1;

  i2c_host_command_interface u_dut (.mclk(mclk), .srst(srst), .ce(ce), .scl(scl), .sdaIn(sdaLine),
    .sdaOut(sdaOut), .sdaOeN(sdaOeN), .addressSelectPin(addressSelectPin), .lineBusyFlag(lineBusyFlag),
    .asleep(asleep), .regs(regs), .cmd(cmd), .readPointer(readPointer));

  i2c_master_model u_master (.mclk(mclk), .sda(sdaLine), .scl(scl), .drvLow(drvLow));

  // --------------------------------
  // Helpers
  // --------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask : chk

  task automatic finish_test;
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : finish_test

  function automatic logic [7:0] ad(input logic rw);
    return {i2c_host_pkg::ADDR_UPPER_BITS, addressSelectPin, rw};
  endfunction : ad

  // Stops at the first refused byte, as a master must
  task automatic xfer(input logic [23:0] b, input int n, output logic [2:0] a);
    logic ack;
    a = 3'h0;
    u_master.start_cond();
    for (int i = 0; i < n; i++) begin
      u_master.wbyte(b[23 - 8 * i -: 8], ack);
      a[2 - i] = ack;
      if (!ack) break;
    end
    u_master.stop_cond();
  endtask : xfer

  // --------------------------------
  // Scenarios
  // --------------------------------
  task automatic t_addr;
    logic [2:0] a;
    chk(sdaOeN, 1'b1, "idle release");
    chk(sdaOut, 1'b0, "open drain value");
    for (int s = 0; s < 2; s++) begin
      addressSelectPin = s[0];
      u_master.wt(8);
      xfer({ad(1'b0), 16'h0000}, 1, a);
      chk(a, 3'h4, "own address");
      xfer({ad(1'b0) ^ 8'h02, 16'h0000}, 1, a);
      chk(a, 3'h0, "other address");
    end
    // Clock enable low must freeze the whole slave, bus included
    ce = 1'b0;
    xfer({ad(1'b0), 8'hd2, 8'h3c}, 3, a);
    chk(a, 3'h0, "frozen ack");
    chk(readPointer, 8'hf0, "frozen pointer");
    ce = 1'b1;
    u_master.wt(8);
    asleep = 1'b1;
    xfer({ad(1'b0), 16'h0000}, 1, a);
    chk(a, 3'h0, "asleep");
    asleep = 1'b0;
  endtask : t_addr

  task automatic t_codes;
    logic [7:0] codes[8] = '{8'he1, 8'hd2, 8'hf0, 8'hb4, 8'h87, 8'ha5, 8'h96, 8'h78};
    logic [2:0] a;
    logic [7:0] c;
    logic [7:0] p;
    logic h;
    int k;
    foreach (codes[i]) begin
      c = codes[i];
      h = c inside {8'he1, 8'hd2, 8'h87, 8'ha5, 8'h78};
      p = (c == 8'he1) ? 8'hc3 : 8'h3c;
      k = nStrobe;
      xfer({ad(1'b0), c, p}, h ? 3 : 2, a);
      chk(a, h ? 3'h7 : 3'h6, "command acks");
      chk(nStrobe - k, 1, "strobe count");
      chk(cmd.code, c, "code");
      chk(cmd.hasParam, h, "param flag");
      if (h) chk(cmd.param, p, "param");
      chk(readPointer, (c == 8'he1) ? p : (c == 8'hd2) ? 8'hc3 : 8'hf0, "pointer");
    end
  endtask : t_codes

  task automatic t_refuse;
    logic [7:0] busy[6] = '{8'hb4, 8'h87, 8'ha5, 8'h96, 8'h78, 8'hd2};
    logic [2:0] a;
    int k;
    k = nStrobe;
    xfer({ad(1'b0), 8'he1, 8'he5}, 3, a);
    chk(a, 3'h6, "bad pointer");
    chk(readPointer, 8'hf0, "pointer kept");
    xfer({ad(1'b0), 8'hf0, 8'h3c}, 3, a);
    chk(a, 3'h6, "surplus byte");
    xfer({ad(1'b0), 8'h00, 8'h00}, 2, a);
    chk(a, 3'h4, "unknown code");
    lineBusyFlag = 1'b1;
    foreach (busy[i]) begin
      xfer({ad(1'b0), busy[i], 8'h3c}, 3, a);
      chk(a, 3'h4, "busy code");
    end
    lineBusyFlag = 1'b0;
    chk(nStrobe - k, 1, "refused strobes");
  endtask : t_refuse

  // Pointer write, then repeated start into a polled read
  task automatic t_read(input logic [7:0] ptr, input logic [7:0] exp);
    logic ack;
    logic [7:0] d;
    u_master.start_cond();
    u_master.wbyte(ad(1'b0), ack);
    u_master.wbyte(8'he1, ack);
    u_master.wbyte(ptr, ack);
    chk(ack, 1'b1, "pointer ack");
    u_master.start_cond();
    u_master.wbyte(ad(1'b1), ack);
    chk(ack, 1'b1, "read address");
    for (int i = 0; i < 3; i++) begin
      u_master.rbyte(i < 2, d);
      chk(d, exp, "read byte");
    end
    u_master.wt(8);
    chk(sdaLine, 1'b1, "released after nack");
    u_master.stop_cond();
  endtask : t_read

  task automatic t_rates;
    // Quarter bit times that keep both rates at or under their limits
    int qs[2] = '{313, 79};
    logic [2:0] a;
    foreach (qs[i]) begin
      u_master.tq = qs[i];
      xfer({ad(1'b0), 8'hf0, 8'h00}, 2, a);
      chk(a, 3'h6, "bus rate");
    end
    u_master.tq = 12;
  endtask : t_rates

  initial begin
    repeat (4) @(posedge mclk);
    #1;
    srst = 1'b0;
    u_master.wt(4);
    t_addr();
    t_codes();
    t_refuse();
    t_read(8'he1, regs.data);
    t_read(8'hc3, regs.cfg);
    t_read(8'hf0, regs.status);
    t_rates();
    finish_test();
  end

  // Expected run is about 63k cycles
  initial begin
    #720000;
    err_total++;
    finish_test();
  end

endmodule : i2c_host_command_interface_tb_top
